//--- bench/timer_pulse_measure_capture_regs_bench.sv
// self-checking bench for the pulse-measuring timer
`timescale 1ns/1ps
`include "tmr_defs.vh"
module timer_pulse_measure_capture_regs_bench;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
  logic we_i = 1'h0, run = 1'h0, re;
  logic [7:0] adr_i = 8'h0, per = 8'h10, hi = 8'h8;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, seed = 32'h12;
  logic [15:0] rv, v0;
  logic ack_o, err_o, pa, pb, dma_req_o, irq_capture_a_o, irq_any_o;
  logic cmp_a, cmp_b, irq_cmpa, irq_ov, irq_capb, irq_cmpb;
  int n_errors = 0, total_checks = 0, dcnt = 0, d0;
  int ca = 0, cb = 0, ca0, cb0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (dma_req_o) dcnt <= dcnt + 1;
  always @(posedge clk_i) if (cmp_a) ca <= ca + 1;
  always @(posedge clk_i) if (cmp_b) cb <= cb + 1;
  timer_pulse_measure_capture_regs u_timer_pulse_measure_capture_regs (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .capture_input_a_i(pa), .capture_input_b_i(pb),
    .ext_clk_i(1'h0), .compare_output_a_o(cmp_a),
    .compare_output_b_o(cmp_b), .irq_capture_a_o,
    .irq_compare_a_o(irq_cmpa), .irq_overflow_o(irq_ov),
    .irq_capture_b_o(irq_capb), .irq_compare_b_o(irq_cmpb), .irq_any_o,
    .dma_req_o);
  wave_src u_wave_src (.clk_i, .run_i(run), .per_i(per), .hi_i(hi),
    .pin_a_o(pa), .pin_b_o(pb));
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic waitn(int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [15:0] d, logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_o && !err_o && n < 20);
    if (n == 20) begin
      n_errors++;
      give_verdict();
    end
    rv = dat_o[15:0];
    re = err_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    wb(1'h1, a, d, 4'hf);
  endtask
  task automatic rd(logic [7:0] a);
    wb(1'h0, a, 16'h0, 4'hf);
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [15:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask
  // two full periods plus one more high phase of the wave, then quiet time for matches
  task automatic burst();
    d0 = dcnt;
    ca0 = ca;
    cb0 = cb;
    run <= 1'h1;
    waitn(2 * per + hi + 4);
    run <= 1'h0;
    waitn(40);
  endtask
  initial begin
    waitn(12);
    rst_i <= 1'h0;
    rchk("cmpa_rst", `ADR_CMPA, `CMPA_RST);
    rchk("cmpb_rst", `ADR_CMPB, `CMPB_RST);
    rchk("ctl1_rst", `ADR_CTL1, `CTL_RST);
    rchk("flag_rst", `ADR_FLAGS, 16'h0);
    waitn(20);
    rchk("cnt_stop", `ADR_CNT, `CNT_RST);
    v0 = rnd();
    wr(`ADR_CMPA, v0);
    rchk("cmpa_rw", `ADR_CMPA, v0);
    wb(1'h1, `ADR_CMPA, ~v0, 4'h1);
    chk("sel_err", re, 1'h1);
    rchk("cmpa_keep", `ADR_CMPA, v0);
    v0 = rnd();
    wr(`ADR_CMPB, v0);
    rchk("cmpb_rw", `ADR_CMPB, v0);
    wr(`ADR_CNT, rnd());
    rchk("cnt_wr", `ADR_CNT, `CNT_RST);
    wr(`ADR_CAPA, rnd());
    rchk("capa_ro", `ADR_CAPA, 16'h0);
    wr(`ADR_CAPB, rnd());
    rchk("capb_ro", `ADR_CAPB, 16'h0);
    rd(8'h20);
    chk("unmapped", re, 1'h1);
    $display("test registers ended");
    wr(`ADR_CTL2, 16'h0003);
    wr(`ADR_CTL1, 16'h8000);
    rd(`ADR_CNT);
    v0 = rv;
    waitn(40);
    rd(`ADR_CNT);
    v0 = rv - v0;
    chk("prescale", v0 > 16'h8 && v0 < 16'hd, 1'h1);
    $display("test prescale ended");
    v0 = rnd();
    hi = 8'h8 + {4'h0, v0[3:0]};
    per = hi + 8'h8 + {4'h0, v0[7:4]};
    wr(`ADR_CTL1, 16'h0);
    wr(`ADR_CTL2, 16'h8400);
    wr(`ADR_CTL1, 16'hc004);
    burst();
    chk("pm_dma", dcnt - d0, 2);
    rd(`ADR_CAPA);
    chk("period", rv + 16'h2 - per < 16'h3, 1'h1);
    rd(`ADR_CAPB);
    chk("width", rv + 16'h2 - hi < 16'h3, 1'h1);
    chk("irq_on", irq_capture_a_o, 1'h1);
    chk("irq_any", irq_any_o, 1'h1);
    wr(`ADR_FLAGS, 16'hffff);
    rd(`ADR_FLAGS);
    chk("flag_keep", rv[15], 1'h1);
    wr(`ADR_CTL2, 16'h0400);
    waitn(3);
    chk("irq_mask", irq_capture_a_o, 1'h0);
    wr(`ADR_CTL2, 16'h8400);
    waitn(3);
    chk("irq_back", irq_capture_a_o, 1'h1);
    wr(`ADR_FLAGS, 16'h7fff);
    waitn(3);
    chk("irq_clr", irq_capture_a_o, 1'h0);
    rd(`ADR_FLAGS);
    chk("flag_clr", rv[15], 1'h0);
    $display("test pulse measure ended");
    wr(`ADR_CMPA, 16'h0010);
    wr(`ADR_CMPB, 16'h0030);
    for (int c = 0; c < 5; c++) begin
      wr(`ADR_CTL2, c == 4 ? 16'h0 : 16'h0400);
      wr(`ADR_CTL1, {2'h2, c[1:0], 12'h00c});
      wr(`ADR_CNT, 16'h0);
      burst();
      chk("dma_sel", dcnt - d0, c == 4 ? 0 : (c[0] ? 1 : 3));
      chk("cmpa_pulse", ca - ca0, 1);
      chk("cmpb_pulse", cb - cb0, 1);
    end
    wr(`ADR_CTL2, 16'h7800);
    waitn(3);
    chk("irq_rest", {irq_cmpa, irq_ov, irq_capb, irq_cmpb}, 4'hf);
    $display("test dma select ended");
    give_verdict();
  end
endmodule // timer_pulse_measure_capture_regs_bench

//--- bench/tmr_chk.sv
// checker on the timer's bus, irq and dma ports
`timescale 1ns/1ps
module tmr_chk (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire ack_o,
  input wire err_o,
  input wire compare_output_a_o,
  input wire irq_capture_a_o,
  input wire irq_compare_a_o,
  input wire irq_overflow_o,
  input wire irq_capture_b_o,
  input wire irq_compare_b_o,
  input wire irq_any_o,
  input wire dma_req_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire [4:0] irqs = {irq_capture_a_o, irq_compare_a_o, irq_overflow_o,
    irq_capture_b_o, irq_compare_b_o};
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  AST_ANSWER:
    assert property (s_req |=> ack_o || err_o)
    else $error("bus request not answered");
  AST_ACK_PULSE:
    assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_SEL_REFUSE:
    assert property (s_req ##0 sel_i[1:0] != 2'h3 |=> err_o)
    else $error("partial word not refused");
  AST_IRQ_ANY:
    assert property ((|irqs) |-> ##[0:1] irq_any_o)
    else $error("shared irq missing");
  AST_DMA_PULSE:
    assert property (dma_req_o |=> !dma_req_o)
    else $error("dma request too long");
  AST_CMP_PULSE:
    assert property (compare_output_a_o |=> !compare_output_a_o)
    else $error("compare pulse too long");
  AST_RESET_QUIET:
    assert property ($fell(rst_i) |-> !irq_any_o && !dma_req_o && !ack_o)
    else $error("outputs busy after reset");
  AST_IRQ_HOLD:
    assert property (irq_capture_a_o && !(cyc_i && stb_i && we_i)
      |=> irq_capture_a_o)
    else $error("irq dropped without a write");
endmodule // tmr_chk
bind timer_pulse_measure_capture_regs tmr_chk u_tmr_chk (.clk_i, .rst_i,
  .cyc_i, .stb_i, .we_i, .sel_i, .ack_o, .err_o, .compare_output_a_o,
  .irq_capture_a_o, .irq_compare_a_o, .irq_overflow_o, .irq_capture_b_o,
  .irq_compare_b_o, .irq_any_o, .dma_req_o);

//--- bench/wave_src.sv
// square wave source for the two capture pins
`timescale 1ns/1ps
module wave_src (
  input wire clk_i,
  input wire run_i,
  input wire [7:0] per_i,
  input wire [7:0] hi_i,
  output wire pin_a_o,
  output wire pin_b_o
);
  logic [7:0] cnt_q;
  always @(posedge clk_i)
    cnt_q <= (!run_i || cnt_q == per_i - 8'h1) ? 8'h0 : cnt_q + 8'h1;
  // pin b inverted so it carries the opposite edge
  assign pin_a_o = run_i && cnt_q < hi_i;
  assign pin_b_o = !pin_a_o;
endmodule // wave_src

//--- core/timer_pulse_measure_capture_regs.v
// 16-bit timer: capture, compare, counter, pulse measure, irq and dma routing
//
// Notes on behaviour
// - pulse-measure mode uses both captures from input A
// - capture A event clears counter in pulse-measure
// - first capture A in pulse-measure raises no irq or dma
// - in pulse-measure, capture A period, capture B pulse width
// - control bit 15 enables counting
// - two-bit field selects dma source
// - one dma request, gated by dma enable
// - each interrupt gated by its enable bit
// - five separate irqs plus one combined
// - registers are accessed as 16-bit words only
// - capture A read-only, loads counter on event
// - capture B read-only, loads counter on event
// - compare A resets to 8000h, drives output A
// - compare B compared with counter, drives output B
// - counter resets and reloads to FFFCh on write
// - edge select 0 falling, 1 rising
// - internal tick is clock over prescale plus one
// - flag clears only on written zero
`timescale 1ns/1ps
`include "tmr_defs.vh"
module timer_pulse_measure_capture_regs (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  input wire capture_input_a_i,
  input wire capture_input_b_i,
  input wire ext_clk_i,
  output reg compare_output_a_o,
  output reg compare_output_b_o,
  output reg irq_capture_a_o,
  output reg irq_compare_a_o,
  output reg irq_overflow_o,
  output reg irq_capture_b_o,
  output reg irq_compare_b_o,
  output reg irq_any_o,
  output reg dma_req_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [15:0] capture_a_value_q;
  reg [15:0] capture_b_value_q;
  reg [15:0] compare_a_value_q;
  reg [15:0] compare_b_value_q;
  reg [15:0] counter_value_q;
  reg [15:0] timer_control_first_q;
  reg [15:0] timer_control_second_q;
  reg [15:0] timer_flags_q;
  reg [7:0] presc_q;
  reg first_cap_q;
  reg [2:0] sync_a_q;
  reg [2:0] sync_b_q;
  reg [2:0] sync_e_q;
  reg lvl_a_q;
  reg lvl_b_q;
  reg lvl_e_q;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_a_q <= 3'b000;
      sync_b_q <= 3'b000;
      sync_e_q <= 3'b000;
      lvl_a_q <= 1'b0;
      lvl_b_q <= 1'b0;
      lvl_e_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], capture_input_a_i};
      sync_b_q <= {sync_b_q[1:0], capture_input_b_i};
      sync_e_q <= {sync_e_q[1:0], ext_clk_i};
      if (sync_a_q[1] == sync_a_q[2])
        lvl_a_q <= sync_a_q[2];
      if (sync_b_q[1] == sync_b_q[2])
        lvl_b_q <= sync_b_q[2];
      if (sync_e_q[1] == sync_e_q[2])
        lvl_e_q <= sync_e_q[2];
    end
  end

  // filtered level changes
  wire a_chg = (sync_a_q[1] == sync_a_q[2]) && (sync_a_q[2] != lvl_a_q);
  wire b_chg = (sync_b_q[1] == sync_b_q[2]) && (sync_b_q[2] != lvl_b_q);
  wire e_chg = (sync_e_q[1] == sync_e_q[2]) && (sync_e_q[2] != lvl_e_q);

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  // edge polarity match
  function edge_hit;
    input chg;
    input new_lvl;
    input sel;
    begin
      edge_hit = chg && (new_lvl == sel);
    end
  endfunction

  wire pmm = timer_control_first_q[`C1_PMM];
  wire en = timer_control_first_q[`C1_EN];
  wire cap_a_ev = edge_hit(a_chg, sync_a_q[2],
                           timer_control_first_q[`C1_EDGA]);
  wire cap_b_ev = pmm ?
    edge_hit(a_chg, sync_a_q[2], timer_control_first_q[`C1_EDGB]) :
    edge_hit(b_chg, sync_b_q[2], timer_control_first_q[`C1_EDGB]);

  // ----------------------------------------------------------------
  // timer tick
  // ----------------------------------------------------------------
  // prescaler divides by factor plus one
  wire presc_done = (presc_q == timer_control_second_q[7:0]);
  wire tick = timer_control_first_q[`C1_ECKEN] ?
    edge_hit(e_chg, sync_e_q[2], timer_control_first_q[`C1_EXEDG]) :
    presc_done;

  always @(posedge clk_i) begin
    if (rst_i || !en || presc_done)
      presc_q <= 8'h00;
    else
      presc_q <= presc_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire word_ok = (sel_i[1:0] == 2'b11);
  wire wr = req && we_i && word_ok;
  wire wr_cnt = wr && (adr_i == `ADR_CNT);
  wire wr_flags = wr && (adr_i == `ADR_FLAGS);

  // ----------------------------------------------------------------
  // counter and compare
  // ----------------------------------------------------------------
  wire match_a = tick && en && (counter_value_q == compare_a_value_q);
  wire match_b = tick && en && (counter_value_q == compare_b_value_q);
  wire ovf = tick && en && (counter_value_q == `CNT_TOP);

  always @(posedge clk_i) begin
    if (rst_i) begin
      counter_value_q <= `CNT_RST;
    end else if (wr_cnt) begin
      counter_value_q <= `CNT_RST;
    end else if (pmm && cap_a_ev) begin
      counter_value_q <= `CNT_ZERO;
    end else if (en && tick) begin
      counter_value_q <= counter_value_q + 16'h0001;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_output_a_o <= 1'b0;
      compare_output_b_o <= 1'b0;
    end else begin
      compare_output_a_o <= match_a;
      compare_output_b_o <= match_b;
    end
  end

  // ----------------------------------------------------------------
  // captures
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      first_cap_q <= 1'b1;
      capture_a_value_q <= 16'h0000;
      capture_b_value_q <= 16'h0000;
    end else begin
      // in pulse-measure, a holds period, b holds width
      if (cap_a_ev)
        capture_a_value_q <= counter_value_q;
      if (cap_b_ev)
        capture_b_value_q <= counter_value_q;
      if (!pmm || !en)
        first_cap_q <= 1'b1;
      else if (cap_a_ev)
        first_cap_q <= 1'b0;
    end
  end

  // suppress first capture A in pulse-measure
  wire ica_ev = cap_a_ev && !(pmm && first_cap_q);

  // ----------------------------------------------------------------
  // flags: set wins over a written zero
  // ----------------------------------------------------------------
  wire [15:0] set_v = {ica_ev, match_a, ovf, cap_b_ev, match_b, 11'h000};
  always @(posedge clk_i) begin
    if (rst_i)
      timer_flags_q <= 16'h0000;
    else if (wr_flags)
      timer_flags_q <= (timer_flags_q & dat_i[15:0]) | set_v;
    else
      timer_flags_q <= timer_flags_q | set_v;
  end

  // ----------------------------------------------------------------
  // interrupts and dma
  // ----------------------------------------------------------------
  // flags gated by enables
  wire [4:0] irq_v = timer_flags_q[15:11] & timer_control_second_q[15:11];
  wire [1:0] dsel = timer_control_first_q[`C1_DMAS_HI:`C1_DMAS_LO];
  reg dma_src;
  always @* begin
    case (dsel)
      `DMA_CAPA: dma_src = ica_ev;
      `DMA_CMPA: dma_src = match_a;
      `DMA_CAPB: dma_src = cap_b_ev;
      default: dma_src = match_b;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_capture_a_o <= 1'b0;
      irq_compare_a_o <= 1'b0;
      irq_overflow_o <= 1'b0;
      irq_capture_b_o <= 1'b0;
      irq_compare_b_o <= 1'b0;
      irq_any_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      irq_capture_a_o <= irq_v[4];
      irq_compare_a_o <= irq_v[3];
      irq_overflow_o <= irq_v[2];
      irq_capture_b_o <= irq_v[1];
      irq_compare_b_o <= irq_v[0];
      irq_any_o <= |irq_v;
      dma_req_o <= dma_src && timer_control_second_q[`C2_DMA_REQUEST_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      compare_a_value_q <= `CMPA_RST;
      compare_b_value_q <= `CMPB_RST;
      timer_control_first_q <= `CTL_RST;
      timer_control_second_q <= `CTL_RST;
    end else if (wr) begin
      if (adr_i == `ADR_CMPA)
        compare_a_value_q <= dat_i[15:0];
      else if (adr_i == `ADR_CMPB)
        compare_b_value_q <= dat_i[15:0];
      else if (adr_i == `ADR_CTL1)
        timer_control_first_q <= dat_i[15:0];
      else if (adr_i == `ADR_CTL2)
        timer_control_second_q <= dat_i[15:0] & `C2_MASK;
    end
  end

  // ----------------------------------------------------------------
  // read and acknowledge
  // ----------------------------------------------------------------
  wire mapped = (adr_i == `ADR_CAPA) || (adr_i == `ADR_CAPB) ||
                (adr_i == `ADR_CMPA) || (adr_i == `ADR_CMPB) ||
                (adr_i == `ADR_CNT) || (adr_i == `ADR_CTL1) ||
                (adr_i == `ADR_CTL2) || (adr_i == `ADR_FLAGS);
  reg [15:0] rd;
  always @* begin
    if (adr_i == `ADR_CAPA)
      rd = capture_a_value_q;
    else if (adr_i == `ADR_CAPB)
      rd = capture_b_value_q;
    else if (adr_i == `ADR_CMPA)
      rd = compare_a_value_q;
    else if (adr_i == `ADR_CMPB)
      rd = compare_b_value_q;
    else if (adr_i == `ADR_CNT)
      rd = counter_value_q;
    else if (adr_i == `ADR_CTL1)
      rd = timer_control_first_q;
    else if (adr_i == `ADR_CTL2)
      rd = timer_control_second_q;
    else if (adr_i == `ADR_FLAGS)
      rd = timer_flags_q;
    else
      rd = 16'h0000;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req && mapped && word_ok;
      err_o <= req && !(mapped && word_ok);
      if (req && !we_i && mapped && word_ok)
        dat_o <= {16'h0000, rd};
    end
  end

endmodule // timer_pulse_measure_capture_regs

//--- core/tmr_defs.vh
// register offsets, field positions, reset values and dma source codes for the timer
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH
`define ADR_CAPA 8'h00
`define ADR_CAPB 8'h04
`define ADR_CMPA 8'h08
`define ADR_CMPB 8'h0c
`define ADR_CNT 8'h10
`define ADR_CTL1 8'h14
`define ADR_CTL2 8'h18
`define ADR_FLAGS 8'h1c
`define CMPA_RST 16'h8000
`define CMPB_RST 16'h0000
`define CNT_RST 16'hfffc
`define CNT_ZERO 16'h0000
`define CNT_TOP 16'hffff
`define CTL_RST 16'h0000
`define C1_EN 15
`define C1_PMM 14
`define C1_DMAS_HI 13
`define C1_DMAS_LO 12
`define C1_EDGB 3
`define C1_EDGA 2
`define C1_EXEDG 1
`define C1_ECKEN 0
`define C2_ICAIE 15
`define C2_OCAIE 14
`define C2_OVERFLOW_IRQ_ENABLE 13
`define C2_ICBIE 12
`define C2_OCBIE 11
`define C2_DMA_REQUEST_ENABLE 10
`define C2_MASK 16'hfcff
`define F_ICA 15
`define F_OCA 14
`define F_TO 13
`define F_ICB 12
`define F_OCB 11
`define DMA_CAPA 2'b00
`define DMA_CMPA 2'b01
`define DMA_CAPB 2'b10
`define DMA_CMPB 2'b11
`endif
